// [design/stofl_pkg.sv]
package stofl_pkg;

    // ****************************************************************
    // Object map
    // ****************************************************************
    localparam logic [15:0] OBJ_FAULT_CAUSE_CODE = 16'h603F;

    // ****************************************************************
    // Cause codes and fieldbus codes
    // ****************************************************************
    localparam logic [15:0] CAUSE_NONE       = 16'h0000;
    localparam logic [15:0] CAUSE_STO        = 16'hFF80;
    localparam logic [15:0] CAUSE_DIAG       = 16'hFF81;
    localparam logic [15:0] CAUSE_SUPPLY     = 16'hFF85;
    localparam logic [11:0] BUS_CODE_NONE    = 12'h000;
    localparam logic [11:0] BUS_CODE_STO     = 12'h11E;
    localparam logic [11:0] BUS_CODE_DIAG    = 12'h11F;
    localparam logic [11:0] BUS_CODE_SUPPLY  = 12'h120;

    // ****************************************************************
    // Control and status word bit positions
    // ****************************************************************
    localparam int unsigned SW_FAULT_BIT     = 3;
    localparam int unsigned CW_RESET_BIT     = 7;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLK_HZ           = 10_000_000;
    localparam int unsigned RESP_MAX_MS      = 100;
    localparam int unsigned RESP_MAX_CYC     = (CLK_HZ / 1000) * RESP_MAX_MS;
    localparam int unsigned DISABLE_LAT_CYC  = 3;

    // ****************************************************************
    // Drive state
    // ****************************************************************
    typedef enum logic [1:0] {
        STOFL_DISABLED = 2'b00,
        STOFL_ENABLED  = 2'b01,
        STOFL_FAULT    = 2'b10
    } stofl_state_t;

endpackage

// [design/stofl_fault_latch.sv]
// Operation
// - STO input asserted while enabled latches recoverable fault FF80 / 11E.
// - Enable request while STO active is refused and latches the same fault.
// - STO asserted while disabled latches nothing; enable allowed once released.
// - Latched STO fault persists and blocks enabling until a reset arrives.
// - Statusword bit 3 is set while any fault is latched.
// - STO-circuit fault cause code is readable in fault_cause_code.
// - Controlword bit 7 rising edge clears resettable faults.
// - Diagnostic failure latches FF81 / 11F; only power cycle clears it.
// - STO supply out of limits latches FF85 / 120; only power cycle clears it.
// - STO function always active; no setting can disable it.
// - Fieldbus STO status is informational and outside the shutdown path.
// - Torque disabled well within 100 ms of the STO input switching.
// - STO during motion removes torque and lets the motor coast.
// - Indicator shows STO activation, also while the drive is disabled.
`timescale 1ns/1ps
module stofl_fault_latch (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        sto_in_n,
    input  wire logic        diag_fail,
    input  wire logic        supply_bad,
    input  wire logic        enable_req,
    input  wire logic [15:0] controlword,
    input  wire logic [15:0] obj_index,
    output logic      [15:0] obj_data,
    output logic             obj_hit,
    output logic      [15:0] statusword,
    output logic      [15:0] fault_cause_code,
    output logic      [11:0] bus_error_code,
    output logic             torque_enable,
    output logic             coast_n,
    output logic             sto_active_led,
    output logic             sto_status
);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [1:0] sync_sto_n;
    logic [1:0] sync_diag;
    logic [1:0] sync_supply;
    logic       sto_active;
    logic       diag_s;
    logic       supply_s;

    // Two flops for every pin from outside the clock domain
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync_sto_n  <= 2'h0;
            sync_diag   <= 2'h0;
            sync_supply <= 2'h0;
        end else begin
            sync_sto_n  <= {sync_sto_n[0], sto_in_n};
            sync_diag   <= {sync_diag[0], diag_fail};
            sync_supply <= {sync_supply[0], supply_bad};
        end
    end

    // Input low means torque is to be removed; reset reads as active
    assign sto_active = ~sync_sto_n[1];
    assign diag_s     = sync_diag[1];
    assign supply_s   = sync_supply[1];

    // ****************************************************************
    // Reset edge detect on controlword bit 7
    // ****************************************************************
    logic cw_reset_q;
    logic reset_edge;

    // Controlword is same-domain logic, so no synchroniser
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cw_reset_q <= 1'b1;
        end else begin
            cw_reset_q <= controlword[stofl_pkg::CW_RESET_BIT];
        end
    end

    assign reset_edge = controlword[stofl_pkg::CW_RESET_BIT] & ~cw_reset_q;

    // ****************************************************************
    // Fault latches and drive state
    // ****************************************************************
    stofl_pkg::stofl_state_t state;
    stofl_pkg::stofl_state_t next_state;
    logic                    sto_fault;
    logic                    next_sto_fault;
    logic                    diag_fault;
    logic                    next_diag_fault;
    logic                    supply_fault;
    logic                    next_supply_fault;
    logic                    any_fault;

    // Next state; fault sets take priority over the reset edge
    always_comb begin
        next_state        = state;
        next_sto_fault    = sto_fault;
        next_diag_fault   = diag_fault | diag_s;
        next_supply_fault = supply_fault | supply_s;
        if (reset_edge) begin
            next_sto_fault = 1'b0;
        end
        case (state)
            stofl_pkg::STOFL_DISABLED: begin
                if (enable_req && sto_active) begin
                    next_sto_fault = 1'b1;
                    next_state     = stofl_pkg::STOFL_FAULT;
                end else if (enable_req && !sto_fault && !next_diag_fault && !next_supply_fault) begin
                    next_state = stofl_pkg::STOFL_ENABLED;
                end
            end
            stofl_pkg::STOFL_ENABLED: begin
                if (sto_active) begin
                    next_sto_fault = 1'b1;
                    next_state     = stofl_pkg::STOFL_FAULT;
                end else if (next_diag_fault || next_supply_fault) begin
                    next_state = stofl_pkg::STOFL_FAULT;
                end else if (!enable_req) begin
                    next_state = stofl_pkg::STOFL_DISABLED;
                end
            end
            stofl_pkg::STOFL_FAULT: begin
                // Leave only when every latched fault is gone
                if (!next_sto_fault && !next_diag_fault && !next_supply_fault) begin
                    next_state = stofl_pkg::STOFL_DISABLED;
                end
            end
            default: begin
                next_state = stofl_pkg::STOFL_FAULT;
            end
        endcase
    end

    // Only the power-on reset clears the safety-class faults
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state        <= stofl_pkg::STOFL_DISABLED;
            sto_fault    <= 1'b0;
            diag_fault   <= 1'b0;
            supply_fault <= 1'b0;
        end else begin
            state        <= next_state;
            sto_fault    <= next_sto_fault;
            diag_fault   <= next_diag_fault;
            supply_fault <= next_supply_fault;
        end
    end

    assign any_fault = sto_fault | diag_fault | supply_fault;

    // ****************************************************************
    // Torque path
    // ****************************************************************
    // Hardwired from the synchronised input; status words never feed it
    always_comb begin
        torque_enable = (state == stofl_pkg::STOFL_ENABLED) & ~sto_active;
        coast_n       = ~sto_active;
    end

    // ****************************************************************
    // Status reporting
    // ****************************************************************
    logic [15:0] next_cause;
    logic [11:0] next_bus_code;
    logic [15:0] next_statusword;

    // Safety-class faults outrank the recoverable one in the cause object
    always_comb begin
        next_cause    = stofl_pkg::CAUSE_NONE;
        next_bus_code = stofl_pkg::BUS_CODE_NONE;
        if (next_diag_fault) begin
            next_cause    = stofl_pkg::CAUSE_DIAG;
            next_bus_code = stofl_pkg::BUS_CODE_DIAG;
        end else if (next_supply_fault) begin
            next_cause    = stofl_pkg::CAUSE_SUPPLY;
            next_bus_code = stofl_pkg::BUS_CODE_SUPPLY;
        end else if (next_sto_fault) begin
            next_cause    = stofl_pkg::CAUSE_STO;
            next_bus_code = stofl_pkg::BUS_CODE_STO;
        end
        next_statusword = 16'h0000;
        next_statusword[stofl_pkg::SW_FAULT_BIT] = next_sto_fault | next_diag_fault | next_supply_fault;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fault_cause_code <= 16'h0000;
            bus_error_code   <= 12'h000;
            statusword       <= 16'h0000;
            sto_active_led   <= 1'b0;
            sto_status       <= 1'b0;
        end else begin
            fault_cause_code <= next_cause;
            bus_error_code   <= next_bus_code;
            statusword       <= next_statusword;
            sto_active_led   <= sto_active;
            sto_status       <= sto_active;
        end
    end

    // ****************************************************************
    // Object read port
    // ****************************************************************
    always_comb begin
        obj_hit  = (obj_index == stofl_pkg::OBJ_FAULT_CAUSE_CODE);
        obj_data = obj_hit ? fault_cause_code : 16'h0000;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_sto_enabled_latch;
        @(posedge clk_sys) disable iff (!resetn)
        (state == stofl_pkg::STOFL_ENABLED && sto_active && !diag_s && !supply_s && !diag_fault && !supply_fault)
            |=> (sto_fault && fault_cause_code == 16'hFF80 && bus_error_code == 12'h11E);
    endproperty
    a_sto_enabled_latch: assert property (p_sto_enabled_latch) else $error("STO while enabled not latched");

    property p_enable_refused;
        @(posedge clk_sys) disable iff (!resetn)
        (state == stofl_pkg::STOFL_DISABLED && enable_req && sto_active)
            |=> (state == stofl_pkg::STOFL_FAULT && sto_fault && !torque_enable);
    endproperty
    a_enable_refused: assert property (p_enable_refused) else $error("Enable not refused under STO");

    property p_disabled_no_fault;
        @(posedge clk_sys) disable iff (!resetn)
        (state == stofl_pkg::STOFL_DISABLED && sto_active && !enable_req && !sto_fault) |=> !sto_fault;
    endproperty
    a_disabled_no_fault: assert property (p_disabled_no_fault) else $error("Fault latched while disabled");

    property p_fault_holds;
        @(posedge clk_sys) disable iff (!resetn)
        (sto_fault && !reset_edge) |=> (sto_fault && state != stofl_pkg::STOFL_ENABLED);
    endproperty
    a_fault_holds: assert property (p_fault_holds) else $error("STO fault lost without reset");

    property p_status_bit;
        @(posedge clk_sys) disable iff (!resetn)
        statusword == {12'h000, (sto_fault | diag_fault | supply_fault), 3'h0};
    endproperty
    a_status_bit: assert property (p_status_bit) else $error("Statusword bit 3 wrong");

    property p_reset_clears;
        @(posedge clk_sys) disable iff (!resetn)
        (reset_edge && !diag_fault && !supply_fault && !diag_s && !supply_s && state == stofl_pkg::STOFL_FAULT)
            |=> (!sto_fault && fault_cause_code == 16'h0000 && !statusword[3]);
    endproperty
    a_reset_clears: assert property (p_reset_clears) else $error("Reset did not clear STO fault");

    property p_diag_sticky;
        @(posedge clk_sys) disable iff (!resetn)
        diag_fault |=> (diag_fault && fault_cause_code == 16'hFF81 && bus_error_code == 12'h11F);
    endproperty
    a_diag_sticky: assert property (p_diag_sticky) else $error("Diagnostic fault cleared");

    property p_supply_sticky;
        @(posedge clk_sys) disable iff (!resetn)
        (supply_fault && !diag_fault) |=> (supply_fault && (diag_fault || fault_cause_code == 16'hFF85));
    endproperty
    a_supply_sticky: assert property (p_supply_sticky) else $error("Supply fault cleared");

    property p_torque_off;
        @(posedge clk_sys) disable iff (!resetn)
        $fell(sto_in_n) |-> ##[1:3] !torque_enable;
    endproperty
    a_torque_off: assert property (p_torque_off) else $error("Torque not removed");

    property p_led;
        @(posedge clk_sys) disable iff (!resetn)
        sto_active |=> sto_active_led;
    endproperty
    a_led: assert property (p_led) else $error("STO indicator not lit");

    // Output-side checks on the torque path and status copies
    property p_coast_free;
        @(posedge clk_sys) disable iff (!resetn)
        sto_active |-> (!coast_n && !torque_enable);
    endproperty
    a_coast_free: assert property (p_coast_free) else $error("Motor not left to coast under STO");

    property p_torque_gate;
        @(posedge clk_sys) disable iff (!resetn)
        torque_enable |-> (state == stofl_pkg::STOFL_ENABLED && !sto_active && !any_fault);
    endproperty
    a_torque_gate: assert property (p_torque_gate) else $error("Torque enabled with STO or fault");

    property p_sto_status;
        @(posedge clk_sys) disable iff (!resetn)
        sto_active |=> sto_status;
    endproperty
    a_sto_status: assert property (p_sto_status) else $error("STO status not reported");

    property p_clear_cause;
        @(posedge clk_sys) disable iff (!resetn)
        ($fell(sto_fault) && !diag_fault && !supply_fault) |-> (fault_cause_code == 16'h0000 && !statusword[3]);
    endproperty
    a_clear_cause: assert property (p_clear_cause) else $error("Cause object not cleared");

endmodule

// [sim/stofl_plc_model.sv]
`timescale 1ns/1ps
// ****************************************************************
// Fieldbus controller model: enable level and controlword
// ****************************************************************
module stofl_plc_model (
    input  wire logic        clk_sys,
    input  wire logic        want_enable,
    input  wire logic        reset_req,
    output logic             enable_req,
    output logic      [15:0] controlword
);
    initial begin
        enable_req  = 1'b0;
        controlword = 16'h0000;
    end

    // Bench requests arrive by NBA, so each is forwarded one falling edge later
    // Reset request shows as a 0-to-1 step on bit 7, driven off the sampling edge
    always @(negedge clk_sys) begin
        enable_req  <= want_enable;
        controlword <= {8'h00, reset_req, 7'h00};
    end
endmodule

// [sim/safe_torque_off_fault_latch_tb.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
// ****************************************************************
// Self-checking bench for the fault latch
// ****************************************************************
module safe_torque_off_fault_latch_tb;
    logic        clk_sys = 1'b0;
    logic        resetn = 1'b0;
    logic        sto_in_n = 1'b1;
    logic        diag_fail = 1'b0;
    logic        supply_bad = 1'b0;
    logic        want_enable = 1'b0;
    logic        reset_req = 1'b0;
    logic        enable_req;
    logic [15:0] controlword;
    logic [15:0] obj_index = 16'h603F;
    logic [15:0] obj_data;
    logic        obj_hit;
    logic [15:0] statusword;
    logic [15:0] fault_cause_code;
    logic [11:0] bus_error_code;
    logic        torque_enable;
    logic        coast_n;
    logic        sto_active_led;
    logic        sto_status;
    int          fail_count = 0;
    int          checks = 0;

    // Clock at 10 MHz
    always #50 clk_sys = ~clk_sys;

    stofl_plc_model PLC (.clk_sys(clk_sys), .want_enable(want_enable), .reset_req(reset_req),
        .enable_req(enable_req), .controlword(controlword));

    stofl_fault_latch DUT (.clk_sys(clk_sys), .resetn(resetn), .sto_in_n(sto_in_n),
        .diag_fail(diag_fail), .supply_bad(supply_bad), .enable_req(enable_req),
        .controlword(controlword), .obj_index(obj_index), .obj_data(obj_data), .obj_hit(obj_hit),
        .statusword(statusword), .fault_cause_code(fault_cause_code),
        .bus_error_code(bus_error_code), .torque_enable(torque_enable), .coast_n(coast_n),
        .sto_active_led(sto_active_led), .sto_status(sto_status));

    // Verdict and end of run
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // Bounded wait for torque to reach a level
    task automatic wait_torque(input logic lvl);
        int i;
        for (i = 0; i < 20 && torque_enable !== lvl; i++) begin
            cyc(1);
        end
        if (torque_enable !== lvl) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, torque_enable, lvl);
            end_sim();
        end
    endtask

    task automatic plc_reset();
        reset_req <= 1'b1;
        cyc(3);
        reset_req <= 1'b0;
        cyc(3);
    endtask

    task automatic power_cycle();
        resetn = 1'b0;
        cyc(2);
        resetn = 1'b1;
        cyc(5);
    endtask

    // STO while disabled: no fault, indication only, enable allowed afterwards
    task automatic t_sto_disabled();
        sto_in_n = 1'b0;
        cyc(5);
        `CHK(statusword, 16'h0000)
        `CHK(fault_cause_code, 16'h0000)
        `CHK(sto_active_led, 1'b1)
        `CHK(sto_status, 1'b1)
        `CHK(coast_n, 1'b0)
        sto_in_n = 1'b1;
        cyc(4);
        want_enable <= 1'b1;
        wait_torque(1'b1);
        `CHK(coast_n, 1'b1)
        $display("Test sto_disabled done");
    endtask

    // STO while enabled: fault latched, held after release, cleared by reset
    task automatic t_sto_enabled();
        sto_in_n = 1'b0;
        wait_torque(1'b0);
        cyc(2);
        `CHK(fault_cause_code, 16'hFF80)
        `CHK(bus_error_code, 12'h11E)
        `CHK(statusword, 16'h0008)
        `CHK(statusword[3], 1'b1)
        `CHK(obj_data, 16'hFF80)
        `CHK(obj_hit, 1'b1)
        sto_in_n = 1'b1;
        cyc(5);
        `CHK(torque_enable, 1'b0)
        `CHK(fault_cause_code, 16'hFF80)
        plc_reset();
        `CHK(fault_cause_code, 16'h0000)
        `CHK(statusword, 16'h0000)
        want_enable <= 1'b0;
        cyc(3);
        want_enable <= 1'b1;
        wait_torque(1'b1);
        $display("Test sto_enabled done");
    endtask

    // Enable attempt under STO is refused and latched
    task automatic t_enable_refused();
        want_enable <= 1'b0;
        cyc(2);
        sto_in_n = 1'b0;
        cyc(5);
        want_enable <= 1'b1;
        cyc(5);
        `CHK(fault_cause_code, 16'hFF80)
        `CHK(torque_enable, 1'b0)
        sto_in_n = 1'b1;
        want_enable <= 1'b0;
        cyc(4);
        plc_reset();
        `CHK(fault_cause_code, 16'h0000)
        $display("Test enable_refused done");
    endtask

    // Safety faults survive the controlword reset and need a power cycle
    task automatic t_safety(input logic sel, input logic [15:0] cause, input logic [11:0] code);
        want_enable <= 1'b1;
        diag_fail = ~sel;
        supply_bad = sel;
        cyc(5);
        diag_fail = 1'b0;
        supply_bad = 1'b0;
        `CHK(fault_cause_code, cause)
        `CHK(bus_error_code, code)
        `CHK(torque_enable, 1'b0)
        `CHK(statusword, 16'h0008)
        plc_reset();
        `CHK(fault_cause_code, cause)
        obj_index = 16'h6040;
        cyc(1);
        `CHK(obj_data, 16'h0000)
        `CHK(obj_hit, 1'b0)
        obj_index = 16'h603F;
        want_enable <= 1'b0;
        power_cycle();
        `CHK(fault_cause_code, 16'h0000)
        $display("Test safety done");
    endtask

    initial begin
        cyc(2);
        resetn = 1'b1;
        cyc(4);
        t_sto_disabled();
        t_sto_enabled();
        t_enable_refused();
        t_safety(1'b0, 16'hFF81, 12'h11F);
        t_safety(1'b1, 16'hFF85, 12'h120);
        end_sim();
    end
endmodule
